// ### core/can_pkg.sv
package can_pkg;

	localparam int unsigned ADDR_W = 12;

	// register byte offsets
	localparam logic [11:0] OFF_MODULE_CTRL0 = 12'h000;
	localparam logic [11:0] OFF_MODULE_CTRL1 = 12'h004;
	localparam logic [11:0] OFF_BIT_TIMING0 = 12'h008;
	localparam logic [11:0] OFF_BIT_TIMING1 = 12'h00C;
	localparam logic [11:0] OFF_RX_FLAG = 12'h010;
	localparam logic [11:0] OFF_RX_IE = 12'h014;
	localparam logic [11:0] OFF_TX_FLAG = 12'h018;
	localparam logic [11:0] OFF_TX_CTRL = 12'h01C;
	localparam logic [11:0] OFF_FILTER_CTRL = 12'h020;
	localparam logic [11:0] OFF_ERR_COUNT = 12'h024;
	localparam logic [11:0] OFF_PATTERN_LO = 12'h040;
	localparam logic [11:0] OFF_PATTERN_HI = 12'h044;
	localparam logic [11:0] OFF_DONTCARE_LO = 12'h048;
	localparam logic [11:0] OFF_DONTCARE_HI = 12'h04C;

	// module_ctrl0 fields
	localparam int unsigned CTRL0_SOFT_RESET = 0;
	localparam int unsigned CTRL0_SLEEP_REQ = 1;
	localparam int unsigned CTRL0_SLEEP_ACK = 2;
	localparam int unsigned CTRL0_STOP_IN_WAIT = 5;

	// rx_flag_reg / rx_ie fields
	localparam int unsigned FLAG_RX_FULL = 0;
	localparam int unsigned FLAG_OVERRUN = 1;
	localparam int unsigned FLAG_BUSOFF = 2;
	localparam int unsigned FLAG_TX_PASSIVE = 3;
	localparam int unsigned FLAG_RX_PASSIVE = 4;
	localparam int unsigned FLAG_TX_WARN = 5;
	localparam int unsigned FLAG_RX_WARN = 6;
	localparam int unsigned FLAG_WAKEUP = 7;

	// filter_ctrl_reg and error count fields
	localparam int unsigned FCTRL_HIT_LSB = 0;
	localparam int unsigned FCTRL_MODE_LSB = 4;
	localparam int unsigned ERR_TEC_LSB = 16;

	localparam logic [1:0] FILT_32 = 2'h0;
	localparam logic [1:0] FILT_16 = 2'h1;
	localparam logic [1:0] FILT_8 = 2'h2;
	localparam logic [1:0] FILT_CLOSED = 2'h3;

	localparam logic [8:0] WARN_LIMIT = 9'h060;
	localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
	localparam logic [8:0] BUSOFF_LIMIT = 9'h0FF;

	localparam logic RST_SOFT_RESET = 1'b1;
	localparam logic [2:0] RST_TX_EMPTY = 3'h7;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [63:0] RST_FILTER = 64'h0;
	localparam logic [1:0] RST_FILT_MODE = FILT_32;

	typedef enum logic [3:0] {
		MODE_NORMAL = 4'b0001,
		MODE_SLEEP = 4'b0010,
		MODE_SOFT_RESET = 4'b0100,
		MODE_POWER_DOWN = 4'b1000
	} can_mode_t;

	typedef struct packed {
		logic valid;
		logic [31:0] id;
	} rx_frame_t;

	typedef struct packed {
		logic [8:0] rec;
		logic [8:0] tec;
	} err_count_t;

	typedef struct packed {
		logic wakeup;
		logic error;
		logic rx;
		logic tx;
	} irq_t;

endpackage : can_pkg

// ### core/accept_filter.sv
module accept_filter (
	input wire logic [1:0] filter_mode,
	input wire logic [63:0] pattern,
	input wire logic [63:0] dontcare,
	input wire logic [31:0] id,
	output logic [7:0] hits,
	output logic hit,
	output logic [2:0] hit_index
);

	// a set dontcare bit removes that bit from the compare
	function automatic logic byte_match(input logic [7:0] p, input logic [7:0] m,
		input logic [7:0] d);
		return &(~(p ^ d) | m);
	endfunction : byte_match

	logic [7:0] m32;
	logic [7:0] m16;
	logic [7:0] m8;

	generate
		for (genvar j = 0; j < 8; j++) begin : g_byte
			assign m32[j] = byte_match(pattern[8*j +: 8], dontcare[8*j +: 8], id[8*(j%4) +: 8]);
			assign m16[j] = byte_match(pattern[8*j +: 8], dontcare[8*j +: 8], id[8*(j%2) +: 8]);
			assign m8[j] = byte_match(pattern[8*j +: 8], dontcare[8*j +: 8], id[7:0]);
		end
	endgenerate

	always_comb begin
		unique case (filter_mode)
			// two filters over the full word
			can_pkg::FILT_32: hits = {6'h00, &m32[7:4], &m32[3:0]};
			// four filters over the first two bytes
			can_pkg::FILT_16: hits = {4'h0, &m16[7:6], &m16[5:4], &m16[3:2], &m16[1:0]};
			// eight filters over the first byte
			can_pkg::FILT_8: hits = m8;
			default: hits = 8'h00;
		endcase
	end

	always_comb begin
		hit_index = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (hits[i]) begin
				hit_index = 3'(i);
			end
		end
	end

	assign hit = |hits;

endmodule : accept_filter

// ### core/can_accept_filter_irq_modes.sv
// The address map and the APB register port were chosen for this implementation.
module can_accept_filter_irq_modes (
	input wire logic clock,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input can_pkg::rx_frame_t rx_frame,
	input wire logic [2:0] tx_sent,
	input can_pkg::err_count_t err_count,
	input wire logic bus_idle,
	input wire logic can_rx_pin,
	input wire logic tx_bit,
	input wire logic cpu_stop,
	input wire logic cpu_wait,
	output logic can_tx_line,
	output can_pkg::irq_t irq,
	output can_pkg::can_mode_t can_mode,
	output logic core_clk_en,
	output logic reg_clk_en,
	output logic rx_copy,
	output logic [7:0] module_ctrl1,
	output logic [15:0] bit_timing
);

	function automatic logic at(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction : at

	logic soft_reset_req_reg;
	logic sleep_req_reg;
	logic sleep_ack_reg;
	logic stop_in_wait_reg;
	logic [7:0] module_ctrl1_reg;
	logic [7:0] bit_timing0_reg;
	logic [7:0] bit_timing1_reg;
	logic [1:0] filter_mode_reg;
	logic [2:0] hit_index_reg;
	logic [63:0] pattern_reg;
	logic [63:0] dontcare_reg;
	logic [7:0] flag_reg;
	logic [7:0] flag_next;
	logic [7:0] ie_reg;
	logic [2:0] tx_empty_reg;
	logic [2:0] tx_ie_reg;
	logic bg_full_reg;
	logic [2:0] bg_hit_reg;
	logic rx_copy_reg;
	logic can_tx_reg;
	logic [31:0] prdata_reg;
	logic rx_meta_reg;
	logic rx_sync_reg;

	logic [7:0] filt_hits;
	logic filt_hit;
	logic [2:0] filt_index;

	logic access;
	logic wr;
	logic mapped;
	logic unlocked;
	logic accept;
	logic fg_take;
	logic wake_event;
	logic overrun_set;
	logic copy_now;
	logic [7:0] cond;
	logic [7:0] set;
	logic [7:0] clr;
	logic [31:0] rd_value;

	accept_filter u_filter (
		.filter_mode(filter_mode_reg),
		.pattern(pattern_reg),
		.dontcare(dontcare_reg),
		.id(rx_frame.id),
		.hits(filt_hits),
		.hit(filt_hit),
		.hit_index(filt_index)
	);

	// receive pin comes from outside the clock domain
	always_ff @(posedge clock) begin
		if (reset) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
		end else begin
			rx_meta_reg <= can_rx_pin;
			rx_sync_reg <= rx_meta_reg;
		end
	end

	always_comb begin
		if (cpu_stop || (cpu_wait && stop_in_wait_reg)) begin
			can_mode = can_pkg::MODE_POWER_DOWN;
		end else if (soft_reset_req_reg) begin
			can_mode = can_pkg::MODE_SOFT_RESET;
		end else if (sleep_ack_reg) begin
			can_mode = can_pkg::MODE_SLEEP;
		end else begin
			can_mode = can_pkg::MODE_NORMAL;
		end
	end

	assign core_clk_en = (can_mode == can_pkg::MODE_NORMAL);
	assign reg_clk_en = (can_mode != can_pkg::MODE_POWER_DOWN);

	assign access = psel & penable;
	assign wr = access & pwrite & reg_clk_en;
	// lock follows the soft reset request
	assign unlocked = soft_reset_req_reg;
	assign mapped = at(paddr, can_pkg::OFF_MODULE_CTRL0) | at(paddr, can_pkg::OFF_MODULE_CTRL1)
		| at(paddr, can_pkg::OFF_BIT_TIMING0) | at(paddr, can_pkg::OFF_BIT_TIMING1)
		| at(paddr, can_pkg::OFF_RX_FLAG) | at(paddr, can_pkg::OFF_RX_IE)
		| at(paddr, can_pkg::OFF_TX_FLAG) | at(paddr, can_pkg::OFF_TX_CTRL)
		| at(paddr, can_pkg::OFF_FILTER_CTRL) | at(paddr, can_pkg::OFF_ERR_COUNT)
		| at(paddr, can_pkg::OFF_PATTERN_LO) | at(paddr, can_pkg::OFF_PATTERN_HI)
		| at(paddr, can_pkg::OFF_DONTCARE_LO) | at(paddr, can_pkg::OFF_DONTCARE_HI);
	assign pready = access;
	assign pslverr = access & ~mapped;

	// dominant level while asleep wakes the module
	assign wake_event = sleep_ack_reg & ~rx_sync_reg;

	always_ff @(posedge clock) begin
		if (reset) begin
			soft_reset_req_reg <= can_pkg::RST_SOFT_RESET;
			stop_in_wait_reg <= 1'b0;
		end else if (wr && at(paddr, can_pkg::OFF_MODULE_CTRL0)) begin
			soft_reset_req_reg <= pwdata[can_pkg::CTRL0_SOFT_RESET];
			stop_in_wait_reg <= pwdata[can_pkg::CTRL0_STOP_IN_WAIT];
		end
	end

	// sleep request cannot be withdrawn before it is acknowledged
	always_ff @(posedge clock) begin
		if (reset) begin
			sleep_req_reg <= 1'b0;
		end else if (wake_event) begin
			sleep_req_reg <= 1'b0;
		end else if (wr && at(paddr, can_pkg::OFF_MODULE_CTRL0)
			&& (pwdata[can_pkg::CTRL0_SLEEP_REQ] || sleep_ack_reg || !sleep_req_reg)) begin
			sleep_req_reg <= pwdata[can_pkg::CTRL0_SLEEP_REQ];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			sleep_ack_reg <= 1'b0;
		end else if (!sleep_req_reg || soft_reset_req_reg || wake_event) begin
			sleep_ack_reg <= 1'b0;
		end else if (bus_idle) begin
			sleep_ack_reg <= 1'b1;
		end
	end

	// configuration writes only while in soft reset
	always_ff @(posedge clock) begin
		if (reset) begin
			module_ctrl1_reg <= 8'h00;
			bit_timing0_reg <= 8'h00;
			bit_timing1_reg <= 8'h00;
			filter_mode_reg <= can_pkg::RST_FILT_MODE;
			pattern_reg <= can_pkg::RST_FILTER;
			dontcare_reg <= can_pkg::RST_FILTER;
		end else if (wr && unlocked) begin
			if (at(paddr, can_pkg::OFF_MODULE_CTRL1)) begin
				module_ctrl1_reg <= pwdata[7:0];
			end
			if (at(paddr, can_pkg::OFF_BIT_TIMING0)) begin
				bit_timing0_reg <= pwdata[7:0];
			end
			if (at(paddr, can_pkg::OFF_BIT_TIMING1)) begin
				bit_timing1_reg <= pwdata[7:0];
			end
			if (at(paddr, can_pkg::OFF_FILTER_CTRL)) begin
				filter_mode_reg <= pwdata[can_pkg::FCTRL_MODE_LSB +: 2];
			end
			if (at(paddr, can_pkg::OFF_PATTERN_LO)) begin
				pattern_reg[31:0] <= pwdata;
			end
			if (at(paddr, can_pkg::OFF_PATTERN_HI)) begin
				pattern_reg[63:32] <= pwdata;
			end
			if (at(paddr, can_pkg::OFF_DONTCARE_LO)) begin
				dontcare_reg[31:0] <= pwdata;
			end
			if (at(paddr, can_pkg::OFF_DONTCARE_HI)) begin
				dontcare_reg[63:32] <= pwdata;
			end
		end
	end

	assign module_ctrl1 = module_ctrl1_reg;
	assign bit_timing = {bit_timing1_reg, bit_timing0_reg};

	always_ff @(posedge clock) begin
		if (reset) begin
			ie_reg <= 8'h00;
			tx_ie_reg <= 3'h0;
		end else if (wr) begin
			if (at(paddr, can_pkg::OFF_RX_IE)) begin
				ie_reg <= pwdata[7:0];
			end
			if (at(paddr, can_pkg::OFF_TX_CTRL)) begin
				tx_ie_reg <= pwdata[2:0];
			end
		end
	end

	// a valid frame end is only taken in normal mode
	assign accept = rx_frame.valid & filt_hit & core_clk_en;
	// foreground takes a message only while rx full is clear
	assign fg_take = ~flag_reg[can_pkg::FLAG_RX_FULL] & core_clk_en;
	assign copy_now = fg_take & (bg_full_reg | accept);
	// third accepted message finds both buffers full
	assign overrun_set = accept & flag_reg[can_pkg::FLAG_RX_FULL] & bg_full_reg;

	// discarded message leaves buffers and transmit untouched
	always_ff @(posedge clock) begin
		if (reset) begin
			bg_full_reg <= 1'b0;
			bg_hit_reg <= 3'h0;
			hit_index_reg <= 3'h0;
		end else if (fg_take && bg_full_reg) begin
			hit_index_reg <= bg_hit_reg;
			bg_full_reg <= accept;
			bg_hit_reg <= accept ? filt_index : bg_hit_reg;
		end else if (fg_take && accept) begin
			// hit index loads with the copy
			hit_index_reg <= filt_index;
		end else if (accept && !bg_full_reg) begin
			bg_full_reg <= 1'b1;
			bg_hit_reg <= filt_index;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			rx_copy_reg <= 1'b0;
		end else begin
			rx_copy_reg <= copy_now;
		end
	end

	assign rx_copy = rx_copy_reg;

	always_comb begin
		cond = 8'h00;
		cond[can_pkg::FLAG_RX_WARN] = err_count.rec >= can_pkg::WARN_LIMIT;
		cond[can_pkg::FLAG_TX_WARN] = err_count.tec >= can_pkg::WARN_LIMIT;
		cond[can_pkg::FLAG_RX_PASSIVE] = err_count.rec > can_pkg::PASSIVE_LIMIT;
		cond[can_pkg::FLAG_TX_PASSIVE] = err_count.tec > can_pkg::PASSIVE_LIMIT;
		cond[can_pkg::FLAG_BUSOFF] = err_count.tec > can_pkg::BUSOFF_LIMIT;
		set = cond;
		set[can_pkg::FLAG_RX_FULL] = copy_now;
		set[can_pkg::FLAG_OVERRUN] = overrun_set;
		// wakeup flag on dominant receive level
		set[can_pkg::FLAG_WAKEUP] = wake_event;
		clr = (wr && at(paddr, can_pkg::OFF_RX_FLAG)) ? pwdata[7:0] : 8'h00;
		flag_next = set | (flag_reg & ~(clr & ~cond));
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			flag_reg <= can_pkg::RST_FLAGS;
		end else begin
			flag_reg <= flag_next;
		end
	end

	// transmit empty flags, set wins over clear
	always_ff @(posedge clock) begin
		if (reset) begin
			tx_empty_reg <= can_pkg::RST_TX_EMPTY;
		end else if (wr && at(paddr, can_pkg::OFF_TX_FLAG)) begin
			tx_empty_reg <= tx_sent | (tx_empty_reg & ~pwdata[2:0]);
		end else begin
			tx_empty_reg <= tx_sent | tx_empty_reg;
		end
	end

	// each output ors its enabled flags
	assign irq.wakeup = flag_reg[can_pkg::FLAG_WAKEUP] & ie_reg[can_pkg::FLAG_WAKEUP];
	assign irq.error = |(flag_reg[6:1] & ie_reg[6:1]);
	assign irq.rx = flag_reg[can_pkg::FLAG_RX_FULL] & ie_reg[can_pkg::FLAG_RX_FULL];
	assign irq.tx = |(tx_empty_reg & tx_ie_reg);

	// recessive whenever the core is not in normal mode
	always_ff @(posedge clock) begin
		if (reset) begin
			can_tx_reg <= 1'b1;
		end else begin
			can_tx_reg <= core_clk_en ? tx_bit : 1'b1;
		end
	end

	assign can_tx_line = can_tx_reg;

	always_comb begin
		rd_value = 32'h00000000;
		if (reg_clk_en) begin
			if (at(paddr, can_pkg::OFF_MODULE_CTRL0)) begin
				rd_value[can_pkg::CTRL0_SOFT_RESET] = soft_reset_req_reg;
				rd_value[can_pkg::CTRL0_SLEEP_REQ] = sleep_req_reg;
				rd_value[can_pkg::CTRL0_SLEEP_ACK] = sleep_ack_reg;
				rd_value[can_pkg::CTRL0_STOP_IN_WAIT] = stop_in_wait_reg;
			end
			if (at(paddr, can_pkg::OFF_MODULE_CTRL1)) rd_value[7:0] = module_ctrl1_reg;
			if (at(paddr, can_pkg::OFF_BIT_TIMING0)) rd_value[7:0] = bit_timing0_reg;
			if (at(paddr, can_pkg::OFF_BIT_TIMING1)) rd_value[7:0] = bit_timing1_reg;
			if (at(paddr, can_pkg::OFF_RX_FLAG)) rd_value[7:0] = flag_reg;
			if (at(paddr, can_pkg::OFF_RX_IE)) rd_value[7:0] = ie_reg;
			if (at(paddr, can_pkg::OFF_TX_FLAG)) rd_value[2:0] = tx_empty_reg;
			if (at(paddr, can_pkg::OFF_TX_CTRL)) rd_value[2:0] = tx_ie_reg;
			if (at(paddr, can_pkg::OFF_FILTER_CTRL)) begin
				rd_value[can_pkg::FCTRL_MODE_LSB +: 2] = filter_mode_reg;
				rd_value[can_pkg::FCTRL_HIT_LSB +: 3] = hit_index_reg;
			end
			if (at(paddr, can_pkg::OFF_ERR_COUNT)) begin
				rd_value[8:0] = err_count.rec;
				rd_value[can_pkg::ERR_TEC_LSB +: 9] = err_count.tec;
			end
			if (at(paddr, can_pkg::OFF_PATTERN_LO)) rd_value = pattern_reg[31:0];
			if (at(paddr, can_pkg::OFF_PATTERN_HI)) rd_value = pattern_reg[63:32];
			if (at(paddr, can_pkg::OFF_DONTCARE_LO)) rd_value = dontcare_reg[31:0];
			if (at(paddr, can_pkg::OFF_DONTCARE_HI)) rd_value = dontcare_reg[63:32];
		end
	end

	// read data is captured in the setup cycle
	always_ff @(posedge clock) begin
		if (reset) begin
			prdata_reg <= 32'h00000000;
		end else if (psel && !penable) begin
			prdata_reg <= rd_value;
		end
	end

	assign prdata = prdata_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_mask_dontcare: assert property (rx_frame.valid && filter_mode_reg == can_pkg::FILT_8
		&& dontcare_reg[63:56] == 8'hFF |-> filt_hit) else $error("masked byte did not hit");
	a_hit_load: assert property (accept && fg_take && !bg_full_reg
		|=> flag_reg[can_pkg::FLAG_RX_FULL] && hit_index_reg == $past(filt_index)
		&& rx_copy) else $error("accept did not load rx full");
	a_lowest_hit: assert property (filt_hit |-> filt_hits[filt_index]
		&& (filt_hits & ((8'h01 << filt_index) - 8'h01)) == 8'h00)
		else $error("hit index not lowest");
	a_closed_mode: assert property (filter_mode_reg == can_pkg::FILT_CLOSED && !bg_full_reg
		&& !flag_reg[can_pkg::FLAG_RX_FULL] |=> !flag_reg[can_pkg::FLAG_RX_FULL])
		else $error("closed filter set rx full");
	a_tx_irq: assert property (tx_sent[0] && tx_ie_reg[0] |=> irq.tx)
		else $error("transmit interrupt missing");
	a_overrun_flag: assert property (overrun_set |=> flag_reg[can_pkg::FLAG_OVERRUN]
		&& bg_hit_reg == $past(bg_hit_reg)) else $error("overrun not flagged");
	a_warn_hold: assert property (err_count.rec >= can_pkg::WARN_LIMIT
		|=> flag_reg[can_pkg::FLAG_RX_WARN] && (irq.error || !ie_reg[can_pkg::FLAG_RX_WARN]))
		else $error("rx warning not held");
	a_busoff_flag: assert property (err_count.tec > can_pkg::BUSOFF_LIMIT
		|=> flag_reg[can_pkg::FLAG_BUSOFF] && flag_reg[can_pkg::FLAG_TX_PASSIVE])
		else $error("bus-off not flagged");
	a_zero_keeps: assert property (flag_reg[can_pkg::FLAG_RX_FULL] && wr
		&& at(paddr, can_pkg::OFF_RX_FLAG) && !pwdata[can_pkg::FLAG_RX_FULL]
		|=> flag_reg[can_pkg::FLAG_RX_FULL]) else $error("zero write cleared flag");
	a_config_lock: assert property (wr && !soft_reset_req_reg
		|=> $stable(bit_timing) && $stable(pattern_reg) && $stable(filter_mode_reg))
		else $error("locked register changed");
	a_stop_recessive: assert property (cpu_stop |-> !reg_clk_en ##1 can_tx_line)
		else $error("tx not recessive in stop");
	a_wakeup_flag: assert property (sleep_ack_reg && !rx_sync_reg
		|=> flag_reg[can_pkg::FLAG_WAKEUP] && !sleep_ack_reg) else $error("no wakeup");
	a_copy_guard: assert property (flag_reg[can_pkg::FLAG_RX_FULL] && !wr
		|=> $stable(hit_index_reg) ##1 !rx_copy) else $error("copy into full buffer");

	c_overrun: cover property (overrun_set);
	c_pending_copy: cover property (bg_full_reg ##1 !bg_full_reg && flag_reg[0]);
	c_wakeup: cover property (sleep_ack_reg ##[1:8] irq.wakeup);
	c_hit16: cover property (accept && filter_mode_reg == can_pkg::FILT_16 && filt_index == 3'h3);

endmodule : can_accept_filter_irq_modes

// ### tb/can_engine_model.sv
module can_engine_model (
	input wire logic clock,
	output can_pkg::rx_frame_t rx_frame,
	output logic can_rx_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		rx_frame = '0;
		can_rx_pin = 1'b1;
	end

	task automatic send_frame(input logic [31:0] id);
		@(posedge clock);
		rx_frame <= '{valid: 1'b1, id: id};
		@(posedge clock);
		rx_frame.valid <= 1'b0;
		// released id no longer shows the last value
		rx_frame.id <= ~id;
	endtask : send_frame

	// dominant level on the receive pin for n cycles
	task automatic dominant(input int n);
		@(posedge clock);
		can_rx_pin <= 1'b0;
		repeat (n) @(posedge clock);
		can_rx_pin <= 1'b1;
	endtask : dominant
endmodule : can_engine_model

// ### tb/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, reset, psel, penable, pwrite, pready, pslverr, rerr;
	logic can_rx_pin, tx_bit, cpu_stop, can_tx_line, core_clk_en, reg_clk_en, rx_copy;
	logic bus_idle, cpu_wait;
	logic [2:0] tx_sent;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [7:0] module_ctrl1;
	logic [15:0] bit_timing;
	can_pkg::rx_frame_t rx_frame;
	can_pkg::err_count_t err_count;
	can_pkg::irq_t irq;
	can_pkg::can_mode_t can_mode;
	int err_total, comparisons;

	can_accept_filter_irq_modes DUT (.clock(clock), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_frame(rx_frame), .tx_sent(tx_sent),
		.err_count(err_count), .bus_idle(bus_idle), .can_rx_pin(can_rx_pin), .tx_bit(tx_bit),
		.cpu_stop(cpu_stop), .cpu_wait(cpu_wait), .can_tx_line(can_tx_line), .irq(irq),
		.can_mode(can_mode), .core_clk_en(core_clk_en), .reg_clk_en(reg_clk_en),
		.rx_copy(rx_copy), .module_ctrl1(module_ctrl1), .bit_timing(bit_timing));
	can_engine_model eng (.clock(clock), .rx_frame(rx_frame), .can_rx_pin(can_rx_pin));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge clock);
		end
		if (n >= 20) chk("pready", 32'h1, 32'h0);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic t_reset();
		rd(can_pkg::OFF_MODULE_CTRL0);
		chk("soft_reset_req", 32'h1, rdat & 32'h1);
		rd(can_pkg::OFF_TX_FLAG);
		chk("tx_empty", 32'h7, rdat & 32'h7);
		chk("mode", {28'h0, can_pkg::MODE_SOFT_RESET}, {28'h0, can_mode});
	endtask : t_reset

	task automatic t_config();
		apb(1'b1, can_pkg::OFF_PATTERN_LO, 32'h11223344);
		apb(1'b1, can_pkg::OFF_PATTERN_HI, 32'h00000044);
		apb(1'b1, can_pkg::OFF_DONTCARE_LO, 32'h0);
		apb(1'b1, can_pkg::OFF_DONTCARE_HI, 32'hFFFFFF00);
		apb(1'b1, can_pkg::OFF_FILTER_CTRL, 32'h0);
		apb(1'b1, can_pkg::OFF_RX_IE, 32'h1);
		apb(1'b1, can_pkg::OFF_MODULE_CTRL1, 32'h5A);
		apb(1'b1, can_pkg::OFF_BIT_TIMING0, 32'h3C);
		apb(1'b1, can_pkg::OFF_BIT_TIMING1, 32'h81);
		apb(1'b1, can_pkg::OFF_MODULE_CTRL0, 32'h0);
		#5;
		chk("mode", {28'h0, can_pkg::MODE_NORMAL}, {28'h0, can_mode});
		chk("core_clk_en", 32'h1, {31'h0, core_clk_en});
		apb(1'b1, can_pkg::OFF_MODULE_CTRL1, 32'hA5);
		apb(1'b1, can_pkg::OFF_BIT_TIMING0, 32'hFF);
		#5;
		chk("module_ctrl1", 32'h5A, {24'h0, module_ctrl1});
		chk("bit_timing", 32'h813C, {16'h0, bit_timing});
		apb(1'b1, can_pkg::OFF_FILTER_CTRL, 32'h30);
		rd(can_pkg::OFF_FILTER_CTRL);
		chk("filter mode", 32'h0, rdat & 32'h30);
	endtask : t_config

	task automatic t_filter();
		eng.send_frame(32'h11223344);
		rd(can_pkg::OFF_RX_FLAG);
		chk("rx_full", 32'h1, rdat & 32'h1);
		chk("irq rx", 32'h1, {31'h0, irq.rx});
		rd(can_pkg::OFF_FILTER_CTRL);
		chk("hit lowest", 32'h0, rdat & 32'h7);
		apb(1'b1, can_pkg::OFF_RX_FLAG, 32'h0);
		rd(can_pkg::OFF_RX_FLAG);
		chk("rx_full kept", 32'h1, rdat & 32'h1);
		apb(1'b1, can_pkg::OFF_RX_FLAG, 32'h1);
		rd(can_pkg::OFF_RX_FLAG);
		chk("rx_full clear", 32'h0, rdat & 32'h1);
		chk("irq rx low", 32'h0, {31'h0, irq.rx});
		eng.send_frame(32'h00000000);
		rd(can_pkg::OFF_RX_FLAG);
		chk("no hit", 32'h0, rdat & 32'h1);
		eng.send_frame(32'h55667744);
		rd(can_pkg::OFF_FILTER_CTRL);
		chk("hit one", 32'h1, rdat & 32'h7);
	endtask : t_filter

	task automatic t_overrun();
		eng.send_frame(32'h11223344);
		eng.send_frame(32'h11223344);
		rd(can_pkg::OFF_RX_FLAG);
		chk("overrun", 32'h3, rdat & 32'hFF);
		rd(can_pkg::OFF_FILTER_CTRL);
		chk("fg kept", 32'h1, rdat & 32'h7);
		apb(1'b1, can_pkg::OFF_RX_FLAG, 32'h1);
		@(posedge clock);
		#1;
		chk("rx_copy", 32'h1, {31'h0, rx_copy});
		rd(can_pkg::OFF_FILTER_CTRL);
		chk("pending copy", 32'h0, rdat & 32'h7);
		rd(can_pkg::OFF_RX_FLAG);
		chk("rx_full again", 32'h1, rdat & 32'h1);
	endtask : t_overrun

	task automatic t_errors();
		apb(1'b1, can_pkg::OFF_RX_IE, 32'h41);
		err_count <= '{rec: 9'h060, tec: 9'h000};
		rd(can_pkg::OFF_RX_FLAG);
		chk("rx_warn", 32'h40, rdat & 32'h40);
		chk("irq error", 32'h1, {31'h0, irq.error});
		apb(1'b1, can_pkg::OFF_RX_FLAG, 32'h40);
		rd(can_pkg::OFF_RX_FLAG);
		chk("rx_warn held", 32'h40, rdat & 32'h40);
		err_count <= '{rec: 9'h000, tec: 9'h000};
		apb(1'b1, can_pkg::OFF_RX_FLAG, 32'h40);
		rd(can_pkg::OFF_RX_FLAG);
		chk("rx_warn clear", 32'h0, rdat & 32'h40);
		chk("irq error low", 32'h0, {31'h0, irq.error});
		err_count <= '{rec: 9'h000, tec: 9'h100};
		rd(can_pkg::OFF_RX_FLAG);
		chk("tx flags", 32'h2C, rdat & 32'h7C);
		apb(1'b1, can_pkg::OFF_ERR_COUNT, 32'hFFFFFFFF);
		rd(can_pkg::OFF_ERR_COUNT);
		chk("err count", 32'h01000000, rdat);
	endtask : t_errors

	task automatic t_tx_irq();
		chk("irq tx off", 32'h0, {31'h0, irq.tx});
		apb(1'b1, can_pkg::OFF_TX_CTRL, 32'h3);
		#5;
		chk("irq tx on", 32'h1, {31'h0, irq.tx});
		rd(12'hFF0);
		chk("pslverr", 32'h1, {31'h0, rerr});
		apb(1'b1, can_pkg::OFF_TX_FLAG, 32'h7);
		#1;
		chk("irq tx clear", 32'h0, {31'h0, irq.tx});
		tx_sent <= 3'h1;
		@(posedge clock);
		tx_sent <= 3'h0;
		#1;
		chk("irq tx sent", 32'h1, {31'h0, irq.tx});
		rd(can_pkg::OFF_TX_FLAG);
		chk("tx_empty sent", 32'h1, rdat & 32'h7);
	endtask : t_tx_irq

	task automatic set_filter(input logic [31:0] m);
		apb(1'b1, can_pkg::OFF_RX_FLAG, 32'h1);
		apb(1'b1, can_pkg::OFF_MODULE_CTRL0, 32'h1);
		apb(1'b1, can_pkg::OFF_FILTER_CTRL, m);
		apb(1'b1, can_pkg::OFF_MODULE_CTRL0, 32'h0);
	endtask : set_filter

	task automatic t_modes();
		set_filter(32'h10);
		eng.send_frame(32'h00000000);
		rd(can_pkg::OFF_FILTER_CTRL);
		chk("hit 16", 32'h13, rdat & 32'h37);
		set_filter(32'h20);
		eng.send_frame(32'h00000033);
		rd(can_pkg::OFF_FILTER_CTRL);
		chk("hit 8", 32'h21, rdat & 32'h37);
		set_filter(32'h30);
		eng.send_frame(32'h00000000);
		rd(can_pkg::OFF_RX_FLAG);
		chk("closed", 32'h0, rdat & 32'h1);
	endtask : t_modes

	task automatic t_sleep();
		apb(1'b1, can_pkg::OFF_RX_IE, 32'h80);
		bus_idle <= 1'b0;
		apb(1'b1, can_pkg::OFF_MODULE_CTRL0, 32'h2);
		rd(can_pkg::OFF_MODULE_CTRL0);
		chk("busy no sleep", 32'h2, rdat & 32'h6);
		bus_idle <= 1'b1;
		rd(can_pkg::OFF_MODULE_CTRL0);
		chk("sleep_ack", 32'h6, rdat & 32'h6);
		chk("mode", {28'h0, can_pkg::MODE_SLEEP}, {28'h0, can_mode});
		chk("core_clk_en", 32'h0, {31'h0, core_clk_en});
		chk("irq wakeup off", 32'h0, {31'h0, irq.wakeup});
		eng.dominant(4);
		rd(can_pkg::OFF_RX_FLAG);
		chk("wakeup", 32'h80, rdat & 32'h80);
		chk("irq wakeup", 32'h1, {31'h0, irq.wakeup});
		rd(can_pkg::OFF_MODULE_CTRL0);
		chk("woken", 32'h0, rdat & 32'h6);
		cpu_wait <= 1'b1;
		#1;
		chk("wait run", {28'h0, can_pkg::MODE_NORMAL}, {28'h0, can_mode});
		apb(1'b1, can_pkg::OFF_MODULE_CTRL0, 32'h20);
		#1;
		chk("wait pd", {28'h0, can_pkg::MODE_POWER_DOWN}, {28'h0, can_mode});
		cpu_wait <= 1'b0;
	endtask : t_sleep

	task automatic t_stop();
		tx_bit <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk("tx line", 32'h0, {31'h0, can_tx_line});
		cpu_stop <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		chk("tx recessive", 32'h1, {31'h0, can_tx_line});
		chk("mode", {28'h0, can_pkg::MODE_POWER_DOWN}, {28'h0, can_mode});
		chk("reg_clk_en", 32'h0, {31'h0, reg_clk_en});
	endtask : t_stop

	initial begin
		err_total = 0;
		comparisons = 0;
		reset = 1'b1;
		{psel, penable, pwrite, cpu_stop, cpu_wait} = 5'h00;
		tx_sent = 3'h0;
		bus_idle = 1'b1;
		tx_bit = 1'b1;
		paddr = 12'h000;
		pwdata = 32'h0;
		err_count = '0;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		t_reset();
		t_config();
		t_filter();
		t_overrun();
		t_errors();
		t_tx_irq();
		t_modes();
		t_sleep();
		t_stop();
		end_of_test();
	end

	initial begin
		repeat (5000) @(posedge clock);
		err_total++;
		end_of_test();
	end
endmodule : tb_top
